// ==== ilsr_mgmt_model.sv ====
// Management controller model: issues commands and accepts response words.
`timescale 1ns/1ps
module ilsr_mgmt_model (
  input  wire logic        core_clk,    // Clock.
  input  wire logic        slowReady,   // High stalls every other cycle.
  output logic             cmdValid,    // Command pulse.
  output logic [7:0]       cmdType,     // Command code.
  output logic             cmdBadSum,   // Checksum error flag.
  output logic             cmdBadId,    // Identifier mismatch flag.
  output logic [31:0]      rspChecksum, // Checksum word for the reply.
  output logic             rspReady,    // Word accept.
  input  wire logic        rspValid,    // Word offered.
  input  wire logic [7:0]  rspType,     // Reply type.
  input  wire logic [31:0] rspWord,     // Reply word.
  input  wire logic        rspLast,     // Checksum word flag.
  input  wire logic        cmdDropped   // Refusal pulse.
);
  logic [31:0] gotWords [0:3]; // Captured reply words.
  logic [7:0]  gotType;        // Type seen with the last word.
  int          gotCount  = 0;  // Words accepted in this reply.
  int          doneCount = 0;  // Replies completed.
  int          dropCount = 0;  // Refusals seen.
  logic        phase     = 1'b0; // Toggles for the slow pattern.
  initial begin
    cmdValid = 1'b0;
    cmdType = 8'h00;
    cmdBadSum = 1'b0;
    cmdBadId = 1'b0;
    rspChecksum = 32'h0;
    rspReady = 1'b0;
  end
  // A command is header only: code, two error flags and a checksum, no payload.
  task send_cmd(input logic [7:0] code, input logic bSum, input logic bId, input logic [31:0] sum);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdType <= code;
    cmdBadSum <= bSum;
    cmdBadId <= bId;
    rspChecksum <= sum;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    // Outside the pulse the qualifiers carry the inverse, so a stale value cannot pass.
    cmdType <= ~code;
    cmdBadSum <= ~bSum;
    cmdBadId <= ~bId;
  endtask : send_cmd
  // Accepts words at once or on alternate cycles, as the slow mode asks.
  always @(posedge core_clk) begin
    phase <= ~phase;
    rspReady <= slowReady ? phase : 1'b1;
  end
  // Captures each accepted word and counts completed replies and refusals.
  // A new command starts a fresh reply count.
  always @(posedge core_clk) begin
    if (cmdValid === 1'b1) begin
      gotCount <= 0;
    end
    if (rspValid === 1'b1 && rspReady === 1'b1) begin
      gotWords[gotCount[1:0]] <= rspWord;
      gotCount <= gotCount + 1;
      gotType <= rspType;
      if (rspLast === 1'b1) begin
        doneCount <= doneCount + 1;
      end
    end
    if (cmdDropped === 1'b1) begin
      dropCount <= dropCount + 1;
    end
  end
endmodule : ilsr_mgmt_model

// ==== ilsr_pkg.sv ====
// Package of constants shared by the link-status responder files.
package ilsr_pkg;

  // ==========================================================================
  // Command and response type codes
  // ==========================================================================
  localparam logic [7:0] CMD_VF_ALLOC_SET  = 8'h36; // Set VF allocation command.
  localparam logic [7:0] RSP_VF_ALLOC_SET  = 8'hb6; // Its response type.
  localparam logic [7:0] CMD_LINK_STATUS   = 8'h38; // Link-status query command.
  localparam logic [7:0] RSP_LINK_STATUS   = 8'hb8; // Its response type.

  // ==========================================================================
  // Response payload word counts and field encodings
  // ==========================================================================
  localparam logic [3:0] WORDS_VF_RSP      = 4'h2; // Codes word, checksum word.
  localparam logic [3:0] WORDS_LINK_RSP    = 4'h4; // Codes, status, speed, checksum.
  localparam logic [3:0] PHYS_LINK_UP      = 4'h5; // Physical state meaning link up.
  localparam logic [3:0] STATE_ETHERNET    = 4'h0; // State code used for Ethernet.
  localparam logic [15:0] CODE_OK          = 16'h0000; // Command completed.
  localparam logic [15:0] REASON_NONE      = 16'h0000; // No reason given.

  // ==========================================================================
  // Wishbone register offsets (byte addresses) and reset values
  // ==========================================================================
  localparam logic [7:0] REG_LINK_CFG      = 8'h00; // Link type, widths, speeds.
  localparam logic [7:0] REG_LINK_STATE    = 8'h04; // Phys and logical state.
  localparam logic [7:0] REG_COUNTS        = 8'h08; // Answered command counters.
  localparam logic [31:0] LINK_CFG_RESET   = 32'h0000_0000; // Ethernet, nothing.
  localparam logic [7:0]  STATE_RESET      = 8'h00; // Ethernet states.

  // Status word bit positions.
  localparam int ACT_WIDTH_POS  = 24; // Running width nibble.
  localparam int CAP_WIDTH_POS  = 16; // Capable widths nibble.
  localparam int LINK_TYPE_POS  = 8;  // Link type bit.
  localparam int PHYS_POS       = 4;  // Physical state nibble.

  // Responder states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } ilsr_state_e;

endpackage : ilsr_pkg

// ==== ilsr_resp_if.sv ====
// Interface carrying response words from the builder to the responder.
`timescale 1ns/1ps
interface ilsr_resp_if;
  logic        isLinkQuery; // High selects the link-status layout.
  logic [1:0]  wordIndex;   // Payload word to build.
  logic [31:0] wordData;    // Built payload word.
  modport builder (input isLinkQuery, input wordIndex, output wordData);
  modport user    (output isLinkQuery, output wordIndex, input wordData);
endinterface : ilsr_resp_if

// ==== ilsr_responder.sv ====
// Top of the link-status responder: command decode, response sequencing, registers.
`timescale 1ns/1ps

module ilsr_responder
  import ilsr_pkg::*;
#(
  parameter bit IB_CAPABLE = 1'b1 // Port can run as InfiniBand.
) (
  input  wire logic        core_clk,   // Clock, 40 MHz.
  input  wire logic        sys_rst,    // Synchronous reset, active high.
  input  wire logic        cmdValid,   // One-cycle pulse: a command arrived.
  input  wire logic [7:0]  cmdType,    // Command type code.
  input  wire logic        cmdBadSum,  // Command failed its checksum.
  input  wire logic        cmdBadId,   // Command identifier mismatch.
  input  wire logic [31:0] rspChecksum,// Checksum word supplied by framing.
  input  wire logic        rspReady,   // Framing accepts a word.
  output logic             rspValid,   // A response word is offered.
  output logic [7:0]       rspType,    // Response type code.
  output logic [31:0]      rspWord,    // Response payload word.
  output logic             rspLast,    // Offered word is the checksum.
  output logic             cmdDropped, // One-cycle pulse: command ignored.
  input  wire logic [31:0] wb_adr_i,   // Wishbone address.
  input  wire logic [31:0] wb_dat_i,   // Wishbone write data.
  input  wire logic [3:0]  wb_sel_i,   // Wishbone byte selects.
  input  wire logic        wb_we_i,    // Wishbone write enable.
  input  wire logic        wb_cyc_i,   // Wishbone cycle.
  input  wire logic        wb_stb_i,   // Wishbone strobe.
  output logic [31:0]      wb_dat_o,   // Wishbone read data.
  output logic             wb_ack_o    // Wishbone acknowledge.
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  ilsr_resp_if     rsp ();           // Builder link.
  ilsr_state_e     stateReg;         // Sequencer state.
  logic [1:0]      wordIdxReg;       // Word being offered.
  logic [3:0]      wordCountReg;     // Words in the current response.
  logic            linkQueryReg;     // Current response is a link query.
  logic [31:0]     linkCfgReg;       // Software link configuration.
  logic [7:0]      linkStateReg;     // Software physical/logical state.
  logic [15:0]     vfCountReg;       // VF answers given.
  logic [15:0]     linkCountReg;     // Link answers given.
  logic            accept;           // A command is taken this cycle.
  logic            isVf;             // Command is VF allocation.
  logic            isLink;           // Command is a supported link query.
  logic            wbReq;            // New Wishbone request.

  // Returns the new byte when its lane is selected, else keeps the old one.
  function automatic logic [7:0] laneMerge(input logic [7:0] oldB, input logic [7:0] newB,
                                           input logic sel);
    laneMerge = sel ? newB : oldB;
  endfunction : laneMerge

  // ==========================================================================
  // Command decode
  // ==========================================================================
  // Errored commands are dropped; the query exists only on capable parts.
  always_comb begin
    isVf   = (cmdType == CMD_VF_ALLOC_SET);
    isLink = (cmdType == CMD_LINK_STATUS) && IB_CAPABLE;
    accept = cmdValid && (stateReg == ST_IDLE) && !cmdBadSum && !cmdBadId
             && (isVf || isLink);
  end

  // ==========================================================================
  // Response sequencer
  // ==========================================================================
  // Offers words one by one until the checksum word is accepted.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stateReg     <= ST_IDLE;
      wordIdxReg   <= 2'd0;
      wordCountReg <= 4'h0;
      linkQueryReg <= 1'b0;
      rspType      <= 8'h00;
    end else begin
      case (stateReg)
        ST_IDLE: begin
          if (accept) begin
            stateReg     <= ST_SEND;
            wordIdxReg   <= 2'd0;
            linkQueryReg <= isLink;
            wordCountReg <= isLink ? WORDS_LINK_RSP : WORDS_VF_RSP;
            rspType      <= isLink ? RSP_LINK_STATUS : RSP_VF_ALLOC_SET;
          end
        end
        ST_SEND: begin
          if (rspValid && rspReady) begin
            if (rspLast) begin
              stateReg <= ST_IDLE;
            end else begin
              wordIdxReg <= wordIdxReg + 2'd1;
            end
          end
        end
        default: stateReg <= ST_IDLE;
      endcase
    end
  end

  assign rsp.isLinkQuery = linkQueryReg;
  assign rsp.wordIndex   = (rspValid && rspReady && !rspLast) ? wordIdxReg + 2'd1
                                                              : wordIdxReg;

  // Builder of payload words from the configured link state.
  ilsr_word_builder u_builder (
    .rsp       (rsp),
    .linkIsIb  (linkCfgReg[0]),
    .runWidth  (linkCfgReg[7:4]),
    .capWidths (linkCfgReg[11:8]),
    .runRate   (linkCfgReg[23:16]),
    .capRates  (linkCfgReg[31:24]),
    .physState (linkStateReg[7:4]),
    .portState (linkStateReg[3:0]),
    .checksum  (rspChecksum)
  );

  // Output words are registered; the next word is loaded on each handshake.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rspValid <= 1'b0;
      rspWord  <= 32'h0000_0000;
      rspLast  <= 1'b0;
    end else if (stateReg == ST_IDLE) begin
      rspValid <= accept;
      rspWord  <= {CODE_OK, REASON_NONE};
      rspLast  <= 1'b0;
    end else if (rspValid && rspReady) begin
      rspValid <= !rspLast;
      rspWord  <= rsp.wordData;
      rspLast  <= ({2'b00, wordIdxReg} + 4'h2) == wordCountReg;
    end
  end

  // Pulse for commands that are not answered.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmdDropped <= 1'b0;
    end else begin
      cmdDropped <= cmdValid && !accept;
    end
  end

  // ==========================================================================
  // Wishbone registers
  // ==========================================================================
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Writes to configuration and state; counters count accepted commands.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      linkCfgReg   <= LINK_CFG_RESET;
      linkStateReg <= STATE_RESET;
    end else if (wbReq && wb_we_i) begin
      if (wb_adr_i[7:0] == REG_LINK_CFG) begin
        for (int b = 0; b < 4; b++) begin
          linkCfgReg[b*8 +: 8] <= laneMerge(linkCfgReg[b*8 +: 8], wb_dat_i[b*8 +: 8],
                                            wb_sel_i[b]);
        end
      end
      if (wb_adr_i[7:0] == REG_LINK_STATE) begin
        linkStateReg <= laneMerge(linkStateReg, wb_dat_i[7:0], wb_sel_i[0]);
      end
    end
  end

  // Response counters, cleared by any write to their register.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      vfCountReg   <= 16'h0000;
      linkCountReg <= 16'h0000;
    end else if (wbReq && wb_we_i && wb_adr_i[7:0] == REG_COUNTS) begin
      vfCountReg   <= 16'h0000;
      linkCountReg <= 16'h0000;
    end else if (accept) begin
      if (isLink) begin
        linkCountReg <= linkCountReg + 16'h0001;
      end else begin
        vfCountReg <= vfCountReg + 16'h0001;
      end
    end
  end

  // Single-cycle acknowledge with registered read data; unmapped reads zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0000_0000;
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i[7:0])
          REG_LINK_CFG:   wb_dat_o <= linkCfgReg & 32'hff_ff_0f_f1;
          REG_LINK_STATE: wb_dat_o <= {24'h000000, linkStateReg};
          REG_COUNTS:     wb_dat_o <= {linkCountReg, vfCountReg};
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_take_link;
    cmdValid && !cmdBadSum && !cmdBadId && cmdType == CMD_LINK_STATUS
      && stateReg == ST_IDLE && IB_CAPABLE;
  endsequence

  property p_link_answer;
    @(posedge core_clk) disable iff (sys_rst)
      s_take_link |=> rspValid && rspType == RSP_LINK_STATUS;
  endproperty
  a_link_answer: assert property (p_link_answer) else $error("query not answered");

  property p_vf_answer;
    @(posedge core_clk) disable iff (sys_rst)
      (accept && isVf) |=> rspValid && rspType == RSP_VF_ALLOC_SET;
  endproperty
  a_vf_answer: assert property (p_vf_answer) else $error("vf request not answered");

  property p_bad_dropped;
    @(posedge core_clk) disable iff (sys_rst)
      (cmdValid && (cmdBadSum || cmdBadId)) |=> cmdDropped && !$rose(rspValid);
  endproperty
  a_bad_dropped: assert property (p_bad_dropped) else $error("bad command answered");

  property p_first_word;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(rspValid) |-> rspWord == {CODE_OK, REASON_NONE} && !rspLast;
  endproperty
  a_first_word: assert property (p_first_word) else $error("codes not first");

  property p_act_width;
    @(posedge core_clk) disable iff (sys_rst)
      (linkQueryReg && rspValid && wordIdxReg == 2'd1 &&
       !(linkCfgReg[0] && linkStateReg[7:4] == PHYS_LINK_UP)) |-> rspWord[31:24] == 8'h00;
  endproperty
  a_act_width: assert property (p_act_width) else $error("width shown while down");

  property p_eth_status;
    @(posedge core_clk) disable iff (sys_rst)
      (linkQueryReg && rspValid && wordIdxReg == 2'd1 && !linkCfgReg[0])
        |-> rspWord == 32'h0000_0000;
  endproperty
  a_eth_status: assert property (p_eth_status) else $error("ethernet status nonzero");

  property p_speed_res;
    @(posedge core_clk) disable iff (sys_rst)
      (linkQueryReg && rspValid && wordIdxReg == 2'd2)
        |-> rspWord[31:24] == 8'h00 && rspWord[15:8] == 8'h00;
  endproperty
  a_speed_res: assert property (p_speed_res) else $error("speed reserved set");

  property p_len;
    @(posedge core_clk) disable iff (sys_rst)
      (rspValid && rspLast) |-> ({2'b00, wordIdxReg} + 4'h1) == wordCountReg;
  endproperty
  a_len: assert property (p_len) else $error("wrong response length");

  // A stalled word, its last flag and the response type stand until accepted.
  property p_hold_word;
    @(posedge core_clk) disable iff (sys_rst)
      (rspValid && !rspReady) |=> rspValid && $stable(rspWord) && $stable(rspLast)
                                  && $stable(rspType);
  endproperty
  a_hold_word: assert property (p_hold_word) else $error("word changed while stalled");

  // Reserved nibbles and bits of the status word go out as zero.
  property p_status_res;
    @(posedge core_clk) disable iff (sys_rst)
      (linkQueryReg && rspValid && wordIdxReg == 2'd1)
        |-> rspWord[31:28] == 4'h0 && rspWord[23:20] == 4'h0 && rspWord[15:9] == 7'h00;
  endproperty
  a_status_res: assert property (p_status_res) else $error("status reserved set");

  // The running rate is hidden unless the link is InfiniBand and physically up.
  property p_act_rate;
    @(posedge core_clk) disable iff (sys_rst)
      (linkQueryReg && rspValid && wordIdxReg == 2'd2 &&
       !(linkCfgReg[0] && linkStateReg[7:4] == PHYS_LINK_UP)) |-> rspWord[23:16] == 8'h00;
  endproperty
  a_act_rate: assert property (p_act_rate) else $error("rate shown while down");

  // On an Ethernet link the whole speed word is zero.
  property p_eth_rate;
    @(posedge core_clk) disable iff (sys_rst)
      (linkQueryReg && rspValid && wordIdxReg == 2'd2 && !linkCfgReg[0])
        |-> rspWord == 32'h0000_0000;
  endproperty
  a_eth_rate: assert property (p_eth_rate) else $error("ethernet speed nonzero");

  // A VF answer is the accepted codes word followed by the checksum word.
  sequence s_vf_codes;
    rspValid && rspReady && !linkQueryReg && !rspLast;
  endsequence

  sequence s_vf_sum;
    rspValid && rspLast && rspType == RSP_VF_ALLOC_SET;
  endsequence

  property p_vf_shape;
    @(posedge core_clk) disable iff (sys_rst)
      s_vf_codes |=> s_vf_sum;
  endproperty
  a_vf_shape: assert property (p_vf_shape) else $error("vf answer shape wrong");

  // The bus acknowledge never lasts longer than one cycle.
  property p_ack_pulse;
    @(posedge core_clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");

endmodule : ilsr_responder

// ==== ilsr_responder_bench.sv ====
// Self-checking bench of the link-status responder.
`timescale 1ns/1ps
module ilsr_responder_bench;
  import ilsr_pkg::*;
  logic        core_clk = 1'b0;  // 40 MHz clock.
  logic        sys_rst  = 1'b1;  // Reset, held two cycles.
  logic        slowReady = 1'b0; // Stall mode of the model.
  logic        cmdValid, cmdBadSum, cmdBadId, rspReady, rspValid, rspLast, cmdDropped;
  logic [7:0]  cmdType, rspType;     // Command and reply codes.
  logic [31:0] rspChecksum, rspWord; // Reply checksum and word.
  logic [31:0] wb_adr_i = 32'h0;     // Bus address.
  logic [31:0] wb_dat_i = 32'h0;     // Bus write data.
  logic [3:0]  wb_sel_i = 4'hf;      // Byte selects.
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;             // Bus read data.
  logic        wb_ack_o;             // Bus acknowledge.
  logic [31:0] rd;                   // Last read value.
  logic [31:0] exp [0:3];            // Expected reply words.
  int          err_count = 0;        // Mismatches.
  int          n_tests = 0;          // Comparisons.
  always #12.5 core_clk = ~core_clk;
  ilsr_responder u_ilsr_responder (.core_clk(core_clk), .sys_rst(sys_rst), .cmdValid(cmdValid),
    .cmdType(cmdType), .cmdBadSum(cmdBadSum), .cmdBadId(cmdBadId), .rspChecksum(rspChecksum),
    .rspReady(rspReady), .rspValid(rspValid), .rspType(rspType), .rspWord(rspWord),
    .rspLast(rspLast), .cmdDropped(cmdDropped), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  ilsr_mgmt_model u_ilsr_mgmt_model (.core_clk(core_clk), .slowReady(slowReady),
    .cmdValid(cmdValid), .cmdType(cmdType), .cmdBadSum(cmdBadSum), .cmdBadId(cmdBadId),
    .rspChecksum(rspChecksum), .rspReady(rspReady), .rspValid(rspValid), .rspType(rspType),
    .rspWord(rspWord), .rspLast(rspLast), .cmdDropped(cmdDropped));
  // Compares one value and counts it.
  task check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask : check
  // Classic single Wishbone cycle, held until ack is sampled high.
  task wb_access(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int guard;
    guard = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {24'h0, adr};
    wb_dat_i <= dat;
    do begin
      @(posedge core_clk);
      guard++;
    end while (wb_ack_o !== 1'b1 && guard < 50);
    if (guard >= 50) err_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask : wb_access
  // Sets the link and works out the status and speed words it must produce.
  task cfg(input logic ib, input logic [3:0] rw, cw, input logic [7:0] rr, cr, input logic [3:0] ph, pt);
    logic up;
    up = ib && (ph == PHYS_LINK_UP);
    wb_access(1'b1, REG_LINK_CFG, {cr, rr, 4'h0, cw, rw, 3'h0, ib});
    wb_access(1'b1, REG_LINK_STATE, {24'h0, ph, pt});
    exp[1] = {4'h0, up ? rw : 4'h0, 4'h0, ib ? cw : 4'h0, 7'h0, ib,
              ib ? ph : 4'h0, ib ? pt : 4'h0};
    exp[2] = {8'h00, up ? rr : 8'h00, 8'h00, ib ? cr : 8'h00};
  endtask : cfg
  // Sends a good command and checks the whole reply.
  task run_cmd(input logic [7:0] code, input logic [7:0] typ, input int n);
    int d, g;
    d = u_ilsr_mgmt_model.doneCount;
    g = 0;
    exp[0] = {CODE_OK, REASON_NONE};
    exp[n - 1] = 32'hc0de_0000 | code;
    u_ilsr_mgmt_model.send_cmd(code, 1'b0, 1'b0, exp[n - 1]);
    while (u_ilsr_mgmt_model.doneCount == d && g < 100) begin
      @(posedge core_clk);
      g++;
    end
    if (g >= 100) err_count++;
    @(posedge core_clk);
    check(u_ilsr_mgmt_model.gotType, typ, "reply type");
    check(u_ilsr_mgmt_model.gotCount, n, "word count");
    for (int i = 0; i < n; i++) check(u_ilsr_mgmt_model.gotWords[i], exp[i], "word");
  endtask : run_cmd
  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // Cuts a hang short.
  initial begin
    #(25 * 20000);
    err_count++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    int d;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    wb_access(1'b0, REG_LINK_CFG, 32'h0);
    check(rd, LINK_CFG_RESET, "cfg reset");
    wb_access(1'b0, REG_LINK_STATE, 32'h0);
    check(rd, {24'h0, STATE_RESET}, "state reset");
    wb_access(1'b1, 8'h0c, 32'hffff_ffff);
    wb_access(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0, "unmapped");
    wb_access(1'b1, REG_LINK_CFG, 32'hffff_ffff);
    wb_access(1'b0, REG_LINK_CFG, 32'h0);
    check(rd, 32'hffff_0ff1, "cfg mask");
    wb_sel_i <= 4'h2;
    wb_access(1'b1, REG_LINK_CFG, 32'h0);
    wb_sel_i <= 4'hf;
    wb_access(1'b0, REG_LINK_CFG, 32'h0);
    check(rd, 32'hffff_00f1, "byte lane");
    $display("test registers done");
    cfg(1'b0, 4'h4, 4'hf, 8'h80, 8'hff, 4'h5, 4'h4);
    run_cmd(CMD_LINK_STATUS, RSP_LINK_STATUS, 4);
    run_cmd(CMD_VF_ALLOC_SET, RSP_VF_ALLOC_SET, 2);
    $display("test ethernet and allocation done");
    slowReady <= 1'b1;
    for (int p = 1; p <= 7; p++) begin
      cfg(1'b1, 4'h1 << (p % 4), 4'hf, 8'h01 << p, 8'hff, p[3:0], p[3:0] % 4 + 1);
      run_cmd(CMD_LINK_STATUS, RSP_LINK_STATUS, 4);
    end
    slowReady <= 1'b0;
    $display("test infiniband states done");
    for (int k = 0; k < 3; k++) begin
      d = u_ilsr_mgmt_model.dropCount;
      u_ilsr_mgmt_model.send_cmd(k == 2 ? 8'h37 : CMD_LINK_STATUS, k == 0, k == 1, 32'h0);
      repeat (4) @(posedge core_clk);
      check(u_ilsr_mgmt_model.dropCount, d + 1, "refusal");
      check(u_ilsr_mgmt_model.gotCount, 0, "no reply");
    end
    $display("test refusals done");
    wb_access(1'b0, REG_COUNTS, 32'h0);
    check(rd, 32'h0008_0001, "answer counts");
    wb_access(1'b1, REG_COUNTS, 32'h0);
    wb_access(1'b0, REG_COUNTS, 32'h0);
    check(rd, 32'h0, "counts cleared");
    $display("test counters done");
    report_and_stop();
  end
endmodule : ilsr_responder_bench

// ==== ilsr_word_builder.sv ====
// Combinational builder of the response payload words.
`timescale 1ns/1ps
module ilsr_word_builder
  import ilsr_pkg::*;
(
  ilsr_resp_if.builder  rsp,          // Word request and result.
  input  wire logic     linkIsIb,     // Configured link type is InfiniBand.
  input  wire logic [3:0] runWidth,   // Running width one-hot.
  input  wire logic [3:0] capWidths,  // Capable widths.
  input  wire logic [7:0] runRate,    // Running rate one-hot.
  input  wire logic [7:0] capRates,   // Capable rates.
  input  wire logic [3:0] physState,  // Physical state.
  input  wire logic [3:0] portState,  // Logical port state.
  input  wire logic [31:0] checksum   // Checksum word supplied by framing.
);
  logic        ibUp;       // InfiniBand and physically up.
  logic [31:0] statusWord; // First status word.
  logic [31:0] speedWord;  // Second status word.

  // Gating of fields by link type and physical state; reserved bits are zero.
  always_comb begin
    ibUp       = linkIsIb && (physState == PHYS_LINK_UP);
    statusWord = '0;
    statusWord[ACT_WIDTH_POS +: 4] = ibUp ? runWidth : 4'h0;
    statusWord[CAP_WIDTH_POS +: 4] = linkIsIb ? capWidths : 4'h0;
    statusWord[LINK_TYPE_POS]      = linkIsIb;
    statusWord[PHYS_POS +: 4]      = linkIsIb ? physState : STATE_ETHERNET;
    statusWord[3:0]                = linkIsIb ? portState : STATE_ETHERNET;
    speedWord  = {8'h00, (ibUp ? runRate : 8'h00),
                  8'h00, (linkIsIb ? capRates : 8'h00)};
  end

  // Word selection; the link layout is codes, status, speed, checksum.
  always_comb begin
    rsp.wordData = '0;
    case (rsp.wordIndex)
      2'd0: rsp.wordData = {CODE_OK, REASON_NONE};
      2'd1: rsp.wordData = rsp.isLinkQuery ? statusWord : checksum;
      2'd2: rsp.wordData = speedWord;
      default: rsp.wordData = checksum;
    endcase
  end
endmodule : ilsr_word_builder
